// ==== rtl/ras_pkg.sv ====
/*
  Shared constants and carrier types for the return-address stack block.
  Assumes a single 40 MHz clock domain and an APB register port.
*/
package ras_pkg;
  localparam int RAS_PC_W = 21;
  localparam int RAS_DEPTH = 31;
  localparam int RAS_PTR_W = 5;
  localparam logic [4:0] RAS_PTR_RESET = 5'h00;
  localparam logic [4:0] RAS_PTR_MAX = 5'h1F;
  localparam logic [20:0] RAS_RESET_VECTOR = 21'h000000;
  localparam logic [20:0] RAS_HIGH_VECTOR = 21'h000008;
  localparam logic [20:0] RAS_LOW_VECTOR = 21'h000018;
  localparam logic [20:0] RAS_MEM_SIZE_SMALL = 21'h001000;
  localparam logic [20:0] RAS_MEM_SIZE_LARGE = 21'h002000;
  localparam logic [20:0] RAS_PC_STEP = 21'h000002;
  localparam logic [15:0] RAS_NOP_WORD = 16'h0000;
  localparam logic [11:0] RAS_OFS_INDEX = 12'h000;
  localparam logic [11:0] RAS_OFS_TOP_LOW = 12'h004;
  localparam logic [11:0] RAS_OFS_TOP_HIGH = 12'h008;
  localparam logic [11:0] RAS_OFS_TOP_UPPER = 12'h00C;
  localparam logic [11:0] RAS_OFS_CONTROL = 12'h010;
  localparam logic [11:0] RAS_OFS_PC = 12'h014;
  localparam int RAS_FULL_BIT = 7;
  localparam int RAS_UNDER_BIT = 6;
  localparam int RAS_CTRL_OVR_RESET_BIT = 0;
  localparam int RAS_CTRL_LARGE_BIT = 1;
  localparam int RAS_CTRL_PUSH_BIT = 2;
  localparam int RAS_CTRL_POP_BIT = 3;
  localparam logic [1:0] RAS_CTRL_RESET = 2'h1;

  typedef enum logic [2:0] {
    RAS_OP_NONE,
    RAS_OP_ABS_CALL,
    RAS_OP_REL_CALL,
    RAS_OP_RETURN,
    RAS_OP_EXIT_LITERAL,
    RAS_OP_IRQ_EXIT,
    RAS_OP_IRQ_ACK,
    RAS_OP_WAKE_IRQ
  } ras_op_type;

  typedef struct packed {
    ras_op_type op;
    logic high_priority;
    logic [20:0] target;
    logic [20:0] next_pc;
  } ras_core_req_type;

  typedef struct packed {
    logic [20:0] pc;
    logic stack_reset;
  } ras_core_rsp_type;
endpackage

// ==== rtl/ras_return_address_stack.sv ====
/*
  Return-address stack, program counter steering and program-space fetch guard.
  Assumes the decoder presents one flow operation per cycle as a request struct,
  APB as the register port, and a synchronous device reset feeding back from
  core_rsp.stack_reset.
*/
`timescale 1ns/1ps
// What this block does
// - Program counter is 21 bits, spanning a 2 Mbyte program space.
// - Fetches above implemented memory but inside the space return zero.
// - Reset starts at 0000h; interrupt entries are 0008h and 0018h.
// - Small variant holds 4 Kbytes, large variant 8 Kbytes of program.
// - Program and data memory use separate buses, usable in one cycle.
// - Stack holds up to 31 nested calls or interrupts.
// - Calls, relative calls and interrupt acknowledges push the request's next_pc.
// - Returns, literal exits and interrupt exits pop the program counter.
// - Calls and returns leave the upper and high latches untouched.
// - Storage is 32 words of 21 bits indexed by a 5-bit pointer; word 0 unused.
// - Every reset clears the pointer to zero.
// - Pointer zero means empty; words map to pointer values 1 to 31.
// - Push increments pointer first, then writes the return address.
// - Pop reads the addressed word, then decrements the pointer.
// - Stack lies outside program and data space; only its registers reach it.
// - Software reads and writes pointer and top word, and may push or pop.
// - Three top bytes show and update the word under the pointer.
// - Flags report full and underflow.
// - Interrupt wake loads vector 0008h when high priority, else 0018h.
// - Interrupt wake pushes the request's next_pc and advances the pointer.
// - Overflow reset option: 31st push stores, flags full, resets, pointer zero.
// - Without option: 31st push flags full at pointer 31; later pushes keep 31, no overwrite.
// - Pop when empty returns zero, flags underflow, pointer stays zero.
// - Index register: full bit 7, underflow bit 6, pointer bits 4..0.
module ras_return_address_stack
  import ras_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_event,
  input wire logic device_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ras_core_req_type core_req,
  output ras_core_rsp_type core_rsp,
  input wire logic [20:0] fetch_addr,
  input wire logic [15:0] flash_rdata,
  output logic [15:0] fetch_word,
  output logic [7:0] pc_upper_latch,
  output logic [7:0] pc_high_latch,
  input wire logic latch_we,
  input wire logic [15:0] latch_wdata
);
  // Storage word 0 exists for indexing but is never read or written.
  logic [RAS_PC_W-1:0] stack_mem [0:RAS_DEPTH];
  logic [RAS_PTR_W-1:0] stack_index_field;
  logic stack_full_flag;
  logic stack_underflow_flag;
  logic stack_overflow_reset_option;
  logic large_variant;
  logic [RAS_PC_W-1:0] pc;
  logic [RAS_PC_W-1:0] top_word;
  logic [RAS_PC_W-1:0] mem_limit;
  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic sw_push;
  logic sw_pop;
  logic hw_push;
  logic hw_pop;
  logic do_push;
  logic do_pop;
  logic irq_entry;
  logic [RAS_PC_W-1:0] push_value;
  logic [RAS_PTR_W-1:0] next_index;
  logic next_full;
  logic next_under;
  logic overflow_reset;
  logic [31:0] next_prdata;

  assign apb_access = psel && penable;
  assign apb_wr = apb_access && pwrite;
  assign apb_rd = apb_access && !pwrite;
  assign sw_push = apb_wr && paddr == RAS_OFS_CONTROL && pwdata[RAS_CTRL_PUSH_BIT];
  assign sw_pop = apb_wr && paddr == RAS_OFS_CONTROL && pwdata[RAS_CTRL_POP_BIT];
  assign irq_entry = core_req.op == RAS_OP_IRQ_ACK || core_req.op == RAS_OP_WAKE_IRQ;
  assign hw_push = core_req.op == RAS_OP_ABS_CALL || core_req.op == RAS_OP_REL_CALL
    || irq_entry;
  assign hw_pop = core_req.op == RAS_OP_RETURN || core_req.op == RAS_OP_EXIT_LITERAL
    || core_req.op == RAS_OP_IRQ_EXIT;
  // Core flow wins over a software push or pop in the same cycle.
  assign do_push = hw_push || (sw_push && !hw_pop);
  assign do_pop = hw_pop || (sw_pop && !hw_push && !sw_push);
  assign push_value = hw_push ? core_req.next_pc : pc;
  assign top_word = (stack_index_field == RAS_PTR_RESET) ? '0
    : stack_mem[stack_index_field];
  assign mem_limit = large_variant ? RAS_MEM_SIZE_LARGE : RAS_MEM_SIZE_SMALL;

  // Pointer and flag next values
  always_comb begin
    next_index = stack_index_field;
    next_full = stack_full_flag;
    next_under = stack_underflow_flag;
    overflow_reset = 1'b0;
    if (apb_wr && paddr == RAS_OFS_INDEX) begin
      next_index = pwdata[RAS_PTR_W-1:0];
      next_full = stack_full_flag && pwdata[RAS_FULL_BIT];
      next_under = stack_underflow_flag && pwdata[RAS_UNDER_BIT];
    end
    if (do_push) begin
      if (stack_index_field == RAS_PTR_MAX) begin
        next_full = 1'b1;
      end else begin
        next_index = stack_index_field + 5'h01;
        if (stack_index_field == RAS_PTR_MAX - 5'h01) begin
          next_full = 1'b1;
          if (stack_overflow_reset_option) begin
            overflow_reset = 1'b1;
          end
        end
      end
    end else if (do_pop) begin
      if (stack_index_field == RAS_PTR_RESET) begin
        next_under = 1'b1;
      end else begin
        next_index = stack_index_field - 5'h01;
      end
    end
  end

  // Pointer clears on any reset; flags only on power-on or software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_index_field <= RAS_PTR_RESET;
    end else if (device_reset || por_event) begin
      stack_index_field <= RAS_PTR_RESET;
    end else if (overflow_reset) begin
      stack_index_field <= RAS_PTR_RESET;
    end else begin
      stack_index_field <= next_index;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_full_flag <= 1'b0;
      stack_underflow_flag <= 1'b0;
    end else if (por_event) begin
      stack_full_flag <= 1'b0;
      stack_underflow_flag <= 1'b0;
    end else begin
      stack_full_flag <= next_full;
      stack_underflow_flag <= next_under;
    end
  end

  // Storage: the full-stack push never overwrites word 31.
  always_ff @(posedge pclk) begin
    if (do_push && stack_index_field != RAS_PTR_MAX) begin
      stack_mem[stack_index_field + 5'h01] <= push_value;
    end else if (apb_wr && stack_index_field != RAS_PTR_RESET) begin
      if (paddr == RAS_OFS_TOP_LOW) begin
        stack_mem[stack_index_field][7:0] <= pwdata[7:0];
      end else if (paddr == RAS_OFS_TOP_HIGH) begin
        stack_mem[stack_index_field][15:8] <= pwdata[7:0];
      end else if (paddr == RAS_OFS_TOP_UPPER) begin
        stack_mem[stack_index_field][20:16] <= pwdata[4:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_overflow_reset_option <= RAS_CTRL_RESET[RAS_CTRL_OVR_RESET_BIT];
      large_variant <= RAS_CTRL_RESET[RAS_CTRL_LARGE_BIT];
    end else if (apb_wr && paddr == RAS_OFS_CONTROL) begin
      stack_overflow_reset_option <= pwdata[RAS_CTRL_OVR_RESET_BIT];
      large_variant <= pwdata[RAS_CTRL_LARGE_BIT];
    end
  end

  // Program counter: calls never touch the latches.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= RAS_RESET_VECTOR;
    end else if (device_reset || por_event || overflow_reset) begin
      pc <= RAS_RESET_VECTOR;
    end else if (irq_entry) begin
      pc <= core_req.high_priority ? RAS_HIGH_VECTOR : RAS_LOW_VECTOR;
    end else if (core_req.op == RAS_OP_ABS_CALL || core_req.op == RAS_OP_REL_CALL) begin
      pc <= core_req.target;
    end else if (hw_pop) begin
      pc <= top_word;
    end else if (core_req.op == RAS_OP_NONE) begin
      pc <= pc + RAS_PC_STEP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_rsp <= '0;
    end else begin
      core_rsp.stack_reset <= overflow_reset;
      core_rsp.pc <= pc;
    end
  end

  // Latches only move on an explicit latch write, never on flow ops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_upper_latch <= 8'h00;
      pc_high_latch <= 8'h00;
    end else if (latch_we) begin
      pc_upper_latch <= latch_wdata[15:8];
      pc_high_latch <= latch_wdata[7:0];
    end
  end

  // Instruction fetch runs on its own port, independent of data access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_word <= RAS_NOP_WORD;
    end else if (fetch_addr >= mem_limit) begin
      fetch_word <= RAS_NOP_WORD;
    end else begin
      fetch_word <= flash_rdata;
    end
  end

  always_comb begin
    next_prdata = 32'h00000000;
    case (paddr)
      RAS_OFS_INDEX: begin
        next_prdata[RAS_FULL_BIT] = stack_full_flag;
        next_prdata[RAS_UNDER_BIT] = stack_underflow_flag;
        next_prdata[RAS_PTR_W-1:0] = stack_index_field;
      end
      RAS_OFS_TOP_LOW: next_prdata[7:0] = top_word[7:0];
      RAS_OFS_TOP_HIGH: next_prdata[7:0] = top_word[15:8];
      RAS_OFS_TOP_UPPER: next_prdata[4:0] = top_word[20:16];
      RAS_OFS_CONTROL: begin
        next_prdata[RAS_CTRL_OVR_RESET_BIT] = stack_overflow_reset_option;
        next_prdata[RAS_CTRL_LARGE_BIT] = large_variant;
      end
      RAS_OFS_PC: next_prdata[RAS_PC_W-1:0] = pc;
      default: next_prdata = 32'h00000000;
    endcase
  end

  // Zero-wait slave: ready rises in the cycle after setup, so the first access cycle completes the transfer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr > RAS_OFS_PC;
      if (psel && !penable && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end
endmodule

// ==== tb/ras_return_address_stack_sva.sv ====
/*
  Port checker for the return-address stack.
  Assumes it is bound to the top module with every port connected by name.
*/
`timescale 1ns/1ps
module ras_return_address_stack_sva
  import ras_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ras_core_req_type core_req,
  input wire ras_core_rsp_type core_rsp,
  input wire logic [20:0] fetch_addr,
  input wire logic [15:0] flash_rdata,
  input wire logic [15:0] fetch_word,
  input wire logic [7:0] pc_upper_latch,
  input wire logic [7:0] pc_high_latch,
  input wire logic latch_we,
  input wire logic [15:0] latch_wdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence wake_s(hp);
    core_req.op == RAS_OP_WAKE_IRQ && core_req.high_priority == hp;
  endsequence
  a_ready_answer: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_error: assert property (pready && paddr > RAS_OFS_PC |->
    pslverr && (pwrite || prdata == 32'h00000000))
    else $error("unmapped offset not refused");
  a_mapped_clean: assert property (pready && paddr <= RAS_OFS_PC |-> !pslverr)
    else $error("mapped offset refused");
  a_fetch_beyond: assert property (fetch_addr >= RAS_MEM_SIZE_LARGE |=>
    fetch_word == RAS_NOP_WORD)
    else $error("fetch beyond memory not zero");
  a_fetch_small: assert property (fetch_addr < RAS_MEM_SIZE_SMALL |=>
    fetch_word == $past(flash_rdata))
    else $error("fetch inside memory wrong");
  a_latch_hold: assert property (!latch_we |=> $stable({pc_upper_latch, pc_high_latch}))
    else $error("latch moved without load");
  a_latch_load: assert property (latch_we |=>
    {pc_upper_latch, pc_high_latch} == $past(latch_wdata))
    else $error("latch load wrong");
  a_wake_high: assert property (wake_s(1'b1) |-> ##[1:2] core_rsp.pc == RAS_HIGH_VECTOR)
    else $error("high wake vector missing");
  a_wake_low: assert property (wake_s(1'b0) |-> ##[1:2] core_rsp.pc == RAS_LOW_VECTOR)
    else $error("low wake vector missing");
  a_reset_pulse: assert property (core_rsp.stack_reset |=> !core_rsp.stack_reset)
    else $error("stack reset longer than a pulse");
endmodule

// ==== tb/ras_core_model.sv ====
/*
  Decoder and program counter model that feeds flow operations to the stack.
  Assumes the bench never overlaps an operation with a register access.
*/
`timescale 1ns/1ps
module ras_core_model
  import ras_pkg::*;
(
  input wire logic pclk,
  output ras_core_req_type core_req
);
  initial core_req = '0;
  // One op per cycle, then idle, so a push is never repeated by accident
  task automatic issue(input ras_op_type o, input logic hp, input logic [20:0] npc);
    @(posedge pclk);
    core_req <= '{op: o, high_priority: hp, target: npc + 21'h000040, next_pc: npc};
    @(posedge pclk);
    core_req.op <= RAS_OP_NONE;
  endtask
endmodule

// ==== tb/ras_return_address_stack_tb_top.sv ====
/*
  Self-checking bench for the return-address stack over APB and the core port.
  Assumes the checker and core model files are compiled before this one.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module ras_return_address_stack_tb_top;
  import ras_pkg::*;
  logic pclk, presetn, por_event, device_reset, psel, penable, pwrite, latch_we;
  logic pready, pslverr, rd_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_val;
  logic [20:0] fetch_addr;
  logic [15:0] flash_rdata, fetch_word, latch_wdata;
  logic [7:0] pc_upper_latch, pc_high_latch;
  ras_core_req_type core_req;
  ras_core_rsp_type core_rsp;
  int num_errors = 0;
  int tests_run = 0;
  int resets_seen = 0;
  ras_return_address_stack ras_return_address_stack_inst (.pclk, .presetn, .por_event,
    .device_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .core_req, .core_rsp, .fetch_addr, .flash_rdata, .fetch_word, .pc_upper_latch,
    .pc_high_latch, .latch_we, .latch_wdata);
  ras_core_model ras_core_model_inst (.pclk, .core_req);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Sampled mid-cycle so a one-cycle pulse is counted exactly once
  always @(negedge pclk) if (core_rsp.stack_reset === 1'b1) resets_seen++;
  task complete_run;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Ready and read data are taken at the rising edge that ends the access
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin num_errors++; complete_run; end
    rd_val = prdata;
    rd_err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd_val, e)
  endtask
  task automatic top_is(input logic [20:0] e);
    rd(RAS_OFS_TOP_LOW, {24'h0, e[7:0]});
    rd(RAS_OFS_TOP_HIGH, {24'h0, e[15:8]});
    rd(RAS_OFS_TOP_UPPER, {27'h0, e[20:16]});
  endtask
  task automatic op(input ras_op_type o, input logic hp, input logic [20:0] npc);
    ras_core_model_inst.issue(o, hp, npc);
  endtask
  task automatic pc_is(input logic [20:0] e);
    @(posedge pclk);
    @(negedge pclk);
    `CHK(core_rsp.pc, e)
  endtask
  task automatic fchk(input logic [20:0] a, input logic [15:0] e);
    @(posedge pclk);
    {fetch_addr, flash_rdata} <= {a, 16'h5A3C};
    @(posedge pclk);
    @(negedge pclk);
    `CHK(fetch_word, e)
  endtask
  task automatic pulse_reset(input logic por);
    @(posedge pclk);
    {por_event, device_reset} <= {por, !por};
    @(posedge pclk);
    {por_event, device_reset} <= 2'b00;
  endtask
  initial begin
    {psel, penable, pwrite, latch_we, por_event, device_reset, presetn} = '0;
    {paddr, pwdata, fetch_addr, flash_rdata, latch_wdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(RAS_OFS_INDEX, 32'h0);
    rd(RAS_OFS_TOP_LOW, 32'h0);
    rd(RAS_OFS_CONTROL, 32'h1);
    rd(12'h018, 32'h0);
    `CHK(rd_err, 1'b1)
    op(RAS_OP_ABS_CALL, 1'b0, 21'h000100);
    op(RAS_OP_REL_CALL, 1'b0, 21'h1ABCDE);
    rd(RAS_OFS_INDEX, 32'h2);
    top_is(21'h1ABCDE);
    op(RAS_OP_RETURN, 1'b0, 21'h0);
    pc_is(21'h1ABCDE);
    op(RAS_OP_EXIT_LITERAL, 1'b0, 21'h0);
    pc_is(21'h000100);
    op(RAS_OP_IRQ_EXIT, 1'b0, 21'h0);
    pc_is(21'h0);
    rd(RAS_OFS_INDEX, 32'h40);
    wr(RAS_OFS_INDEX, 32'h3);
    rd(RAS_OFS_INDEX, 32'h3);
    wr(RAS_OFS_TOP_UPPER, 32'hFF);
    wr(RAS_OFS_TOP_HIGH, 32'hAB);
    wr(RAS_OFS_TOP_LOW, 32'hCD);
    top_is(21'h1FABCD);
    wr(RAS_OFS_CONTROL, 32'h9);
    rd(RAS_OFS_INDEX, 32'h2);
    wr(RAS_OFS_CONTROL, 32'h4);
    rd(RAS_OFS_INDEX, 32'h3);
    wr(RAS_OFS_INDEX, 32'h1E);
    op(RAS_OP_ABS_CALL, 1'b0, 21'h000222);
    rd(RAS_OFS_INDEX, 32'h9F);
    op(RAS_OP_IRQ_ACK, 1'b0, 21'h000444);
    rd(RAS_OFS_INDEX, 32'h9F);
    top_is(21'h000222);
    pulse_reset(1'b0);
    rd(RAS_OFS_INDEX, 32'h80);
    pulse_reset(1'b1);
    rd(RAS_OFS_INDEX, 32'h0);
    wr(RAS_OFS_CONTROL, 32'h1);
    wr(RAS_OFS_INDEX, 32'h1E);
    op(RAS_OP_ABS_CALL, 1'b0, 21'h000666);
    rd(RAS_OFS_INDEX, 32'h80);
    `CHK(resets_seen, 1)
    wr(RAS_OFS_INDEX, 32'h0);
    op(RAS_OP_WAKE_IRQ, 1'b1, 21'h000300);
    pc_is(RAS_HIGH_VECTOR);
    op(RAS_OP_WAKE_IRQ, 1'b0, 21'h000310);
    pc_is(RAS_LOW_VECTOR);
    rd(RAS_OFS_INDEX, 32'h2);
    @(posedge pclk);
    {latch_we, latch_wdata} <= {1'b1, 16'hABCD};
    @(posedge pclk);
    latch_we <= 1'b0;
    op(RAS_OP_ABS_CALL, 1'b0, 21'h000500);
    op(RAS_OP_RETURN, 1'b0, 21'h0);
    `CHK({pc_upper_latch, pc_high_latch}, 16'hABCD)
    fchk(21'h000FFE, 16'h5A3C);
    fchk(21'h001000, 16'h0000);
    wr(RAS_OFS_CONTROL, 32'h3);
    fchk(21'h001000, 16'h5A3C);
    fchk(21'h1FFFFE, 16'h0000);
    complete_run;
  end
endmodule
bind ras_return_address_stack ras_return_address_stack_sva ras_return_address_stack_sva_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .core_req,
  .core_rsp, .fetch_addr, .flash_rdata, .fetch_word, .pc_upper_latch, .pc_high_latch,
  .latch_we, .latch_wdata);
